// >>> flash_self_program_control.sv
// Self-programming controller for on-chip program flash: control byte, arming, commands, lock bits.
// Assumes the CPU presents control writes and store/load strobes on core_clk; the flash array
// reports the end of an erase or write with flashDone.
`include "flash_sp_defines.svh"

module flash_self_program_control
   import flash_sp_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   // Control register access
   input  wire logic        csrWrEn,
   input  wire logic [7:0]  csrWrData,
   output logic [7:0]       csrRdData,
   // CPU instruction side
   input  wire logic        storeInstr,
   input  wire logic        loadInstr,
   input  wire logic [15:0] pointerZ,
   input  wire logic [7:0]  lowWorkingReg,
   input  wire logic [7:0]  highWorkingReg,
   input  wire logic        globalIntEn,
   input  wire logic        execInBoot,
   input  wire logic        vectorsInBoot,
   input  wire logic [1:0]  bootSizeSel,
   // Fuse and signature sources
   input  wire logic [7:0]  fuseLowByte,
   input  wire logic [7:0]  signatureByte,
   input  wire logic        chipErase,
   // Flash array side
   input  wire logic        flashDone,
   output logic             bufWrite,
   output logic [5:0]       bufWordAddr,
   output logic [15:0]      bufWriteData,
   output logic             bufDiscard,
   output logic             pageErase,
   output logic             pageWrite,
   output logic [7:0]       pageAddr,
   // Load answers
   output logic             loadSpecialValid,
   output logic [7:0]       loadSpecialData,
   output logic             loadDenied,
   // CPU and protection status
   output logic             spmReadyIrq,
   output logic             cpuHalt,
   output logic             rwwReadBlock,
   output logic             irqBlock,
   output logic [5:0]       lockBits,
   output logic             extProgBlocked,
   output logic             extVerifyBlocked,
   output logic             fuseLocked,
   output logic             bootLockLocked
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic       irqEnable_reg;
   logic       rwwBusy_reg;
   logic       sigRead_reg;
   logic       reenable_reg;
   logic       lockSet_reg;
   logic       pageWrite_reg;
   logic       pageErase_reg;
   logic       storeEnable_reg;
   logic       bufLoaded_reg;
   logic       haltNrww_reg;
   logic [5:0] lockBits_reg;
   seqState_t  state_reg;

   logic       storeActive;
   logic       storeExpire;
   logic       loadActive;
   logic       cmdValid;
   logic       cmdWrite;
   logic       storeTake;
   logic [4:0] cmdCode;
   logic [13:0] targetWord;
   logic [13:0] loadWord;
   logic [13:0] bootStart;
   logic       targetInBoot;
   logic       targetInRww;
   logic       storeRefused;
   logic       doErase;
   logic       doWrite;
   logic       doFill;
   logic       doLockSet;
   logic       doReenable;
   logic       loadInBoot;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   // Only the five defined codes arm the store; anything else leaves the low bits untouched
   assign cmdCode  = csrWrData[4:0];
   assign cmdValid = (cmdCode == `CMD_REENABLE) || (cmdCode == `CMD_LOCK_SET)
                  || (cmdCode == `CMD_PAGE_WRITE) || (cmdCode == `CMD_PAGE_ERASE)
                  || (cmdCode == `CMD_STORE_ONLY);
   // While programming runs the sequencer is out of ST_IDLE, so new commands are refused
   assign cmdWrite = clkEn && csrWrEn && cmdValid && (state_reg == ST_IDLE);

   // Arming windows: four cycles for stores, three for loads
   arm_window_timer #(
      .WIDTH  (3),
      .LENGTH (`STORE_WINDOW)
   ) storeTimer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .start    (cmdWrite),
      .cancel   (storeTake),
      .active   (storeActive),
      .expire   (storeExpire)
   );

   arm_window_timer #(
      .WIDTH  (3),
      .LENGTH (`LOAD_WINDOW)
   ) loadTimer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clkEn    (clkEn),
      .start    (cmdWrite),
      .cancel   (1'b0),
      .active   (loadActive),
      .expire   ()
   );

   // ----------------------------------------
   // Address and section decode
   // ----------------------------------------
   // Bit 15 of the pointer is never used; bit 0 only selects a byte for loads
   assign targetWord = {pointerZ[14:7], 6'h00};
   assign loadWord   = pointerZ[14:1];

   // Boot section start follows the boot size fuses
   always_comb begin
      unique case (bootSizeSel)
         2'b11:   bootStart = `BOOT_START_256;
         2'b10:   bootStart = `BOOT_START_512;
         2'b01:   bootStart = `BOOT_START_1K;
         default: bootStart = `BOOT_START_2K;
      endcase
   end

   assign targetInBoot = (targetWord >= bootStart);
   assign targetInRww  = (targetWord < `RWW_LIMIT);
   assign loadInBoot   = (loadWord >= bootStart);

   // Section lock on stores: low lock bit programmed means modes 2 and 3
   assign storeRefused = targetInBoot ? !lockBits_reg[`LOCK_BOOT_LO]
                                      : !lockBits_reg[`LOCK_APP_LO];

   // ----------------------------------------
   // Store dispatch
   // ----------------------------------------
   assign storeTake  = clkEn && storeInstr && storeActive && storeEnable_reg && (state_reg == ST_IDLE);
   assign doErase    = storeTake && pageErase_reg && !storeRefused;
   assign doWrite    = storeTake && pageWrite_reg && !storeRefused;
   assign doLockSet  = storeTake && lockSet_reg;
   assign doReenable = storeTake && reenable_reg;
   // A signature-armed store fills nothing; it only clears the armed control bits
   assign doFill     = storeTake && !pageErase_reg && !pageWrite_reg && !lockSet_reg
                    && !reenable_reg && !sigRead_reg;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Stays in the programming state until the array reports completion
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else if (clkEn) begin
         unique case (state_reg)
            ST_IDLE: begin
               if (doErase || doWrite) begin
                  state_reg <= ST_PROG;
               end
            end
            ST_PROG: begin
               if (flashDone) begin
                  state_reg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Control bits
   // ----------------------------------------
   // Command bits clear after use or timeout, but erase/write hold until flashDone
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irqEnable_reg   <= 1'(`CSR_RESET >> `BIT_IRQ_EN);
         sigRead_reg     <= 1'b0;
         reenable_reg    <= 1'b0;
         lockSet_reg     <= 1'b0;
         pageWrite_reg   <= 1'b0;
         pageErase_reg   <= 1'b0;
         storeEnable_reg <= 1'b0;
      end else if (clkEn) begin
         if (csrWrEn) begin
            irqEnable_reg <= csrWrData[`BIT_IRQ_EN];
         end
         if (cmdWrite) begin
            sigRead_reg     <= csrWrData[`BIT_SIG_READ] && (cmdCode == `CMD_STORE_ONLY);
            reenable_reg    <= csrWrData[`BIT_REENABLE];
            lockSet_reg     <= csrWrData[`BIT_LOCK_SET];
            pageWrite_reg   <= csrWrData[`BIT_PAGE_WRITE];
            pageErase_reg   <= csrWrData[`BIT_PAGE_ERASE];
            storeEnable_reg <= csrWrData[`BIT_STORE_EN];
         end else if (doErase || doWrite) begin
            sigRead_reg     <= 1'b0; // Held bits below stay set while the array works
            storeEnable_reg <= 1'b1;
         end else if (storeTake || storeExpire) begin
            sigRead_reg     <= 1'b0;
            reenable_reg    <= 1'b0;
            lockSet_reg     <= 1'b0;
            pageWrite_reg   <= 1'b0;
            pageErase_reg   <= 1'b0;
            storeEnable_reg <= 1'b0;
         end else if ((state_reg == ST_PROG) && flashDone) begin
            pageWrite_reg   <= 1'b0;
            pageErase_reg   <= 1'b0;
            storeEnable_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read-while-write busy flag
   // ----------------------------------------
   // A new programming start wins over any clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rwwBusy_reg <= 1'(`CSR_RESET >> `BIT_RWW_BUSY);
      end else if (clkEn) begin
         if ((doErase || doWrite) && targetInRww) begin
            rwwBusy_reg <= 1'b1;
         end else if (doReenable || doFill) begin
            rwwBusy_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Temporary buffer bookkeeping
   // ----------------------------------------
   // Tracks whether the buffer holds words so a re-enable can flush it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bufLoaded_reg <= 1'b0;
      end else if (clkEn) begin
         if (doFill) begin
            bufLoaded_reg <= 1'b1;
         end else if (doWrite || (cmdWrite && (cmdCode == `CMD_REENABLE))) begin
            bufLoaded_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Flash array strobes
   // ----------------------------------------
   // One-cycle strobes with registered address and data
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bufWrite     <= 1'b0;
         bufWordAddr  <= 6'h00;
         bufWriteData <= 16'h0000;
         bufDiscard   <= 1'b0;
         pageErase    <= 1'b0;
         pageWrite    <= 1'b0;
         pageAddr     <= 8'h00;
      end else if (clkEn) begin
         bufWrite   <= doFill;
         pageErase  <= doErase;
         pageWrite  <= doWrite;
         // Re-enable during loading throws the buffered words away
         bufDiscard <= cmdWrite && (cmdCode == `CMD_REENABLE) && bufLoaded_reg;
         if (doFill) begin
            bufWordAddr  <= pointerZ[6:1];
            bufWriteData <= {highWorkingReg, lowWorkingReg};
         end
         if (doErase || doWrite) begin
            pageAddr <= pointerZ[14:7];
         end
      end
   end

   // ----------------------------------------
   // CPU halt
   // ----------------------------------------
   // Code runs from the no-rww section, so the CPU cannot fetch while it is programmed
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         haltNrww_reg <= 1'b0;
      end else if (clkEn) begin
         if ((doErase || doWrite) && !targetInRww) begin
            haltNrww_reg <= 1'b1;
         end else if ((state_reg == ST_PROG) && flashDone) begin
            haltNrww_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Lock bits
   // ----------------------------------------
   // Bits only move from one to zero here; chip erase is the sole way back
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lockBits_reg <= `LOCK_RESET; // Nonvolatile in silicon; reset models a blank part
      end else if (clkEn) begin
         if (chipErase) begin
            lockBits_reg <= `LOCK_RESET;
         end else if (doLockSet) begin
            lockBits_reg <= lockBits_reg & lowWorkingReg[5:0];
         end
      end
   end

   // ----------------------------------------
   // Load answers
   // ----------------------------------------
   // Armed loads return internal bytes; ordinary loads are only checked for protection
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         loadSpecialValid <= 1'b0;
         loadSpecialData  <= 8'h00;
         loadDenied       <= 1'b0;
      end else if (clkEn) begin
         loadSpecialValid <= 1'b0;
         loadDenied       <= 1'b0;
         if (loadInstr && loadActive && storeEnable_reg && sigRead_reg) begin
            loadSpecialValid <= 1'b1;
            loadSpecialData  <= signatureByte;
         end else if (loadInstr && loadActive && storeEnable_reg && lockSet_reg) begin
            loadSpecialValid <= 1'b1;
            loadSpecialData  <= pointerZ[0] ? fuseLowByte : {2'b11, lockBits_reg};
         end else if (loadInstr) begin
            loadDenied <= (rwwBusy_reg && (loadWord < `RWW_LIMIT))
                       || (execInBoot && !loadInBoot && !lockBits_reg[`LOCK_APP_HI])
                       || (!execInBoot && loadInBoot && !lockBits_reg[`LOCK_BOOT_HI]);
         end
      end
   end

   // ----------------------------------------
   // Status and protection outputs
   // ----------------------------------------
   assign csrRdData = {irqEnable_reg, rwwBusy_reg, sigRead_reg, reenable_reg,
                       lockSet_reg, pageWrite_reg, pageErase_reg, storeEnable_reg};

   // Level request, so software sees it again as soon as store_enable drops
   assign spmReadyIrq  = irqEnable_reg && globalIntEn && !storeEnable_reg;
   assign cpuHalt      = haltNrww_reg;
   assign rwwReadBlock = rwwBusy_reg;

   // Vectors in the other section must not be reached from locked code
   assign irqBlock = vectorsInBoot ? (!execInBoot && !lockBits_reg[`LOCK_APP_HI])
                                   : (execInBoot && !lockBits_reg[`LOCK_BOOT_HI]);

   assign lockBits = lockBits_reg;

   // Memory lock modes; both bits high gives no restriction at all
   assign extProgBlocked   = !(lockBits_reg[`LOCK_MEM_LO] && lockBits_reg[`LOCK_MEM_HI]);
   assign fuseLocked       = extProgBlocked;
   assign extVerifyBlocked = !lockBits_reg[`LOCK_MEM_LO] && !lockBits_reg[`LOCK_MEM_HI];
   assign bootLockLocked   = extVerifyBlocked;

endmodule : flash_self_program_control

// >>> flash_sp_defines.svh
// Constants for the flash self-programming controller: bit positions, reset values, windows, section limits.
// Assumes inclusion by the controller module; definitions only.
// How it works
// - Store-ready interrupt requested while enabled, global flag set and store_enable clear.
// - Erase or write into read-while-write section sets busy flag and blocks its reads.
// - Busy flag clears on re-enable after programming, or when a buffer load starts.
// - Signature select plus store: load within three cycles returns signature byte; store ignored.
// - Re-enable with store within four cycles frees section; refused while programming runs.
// - Re-enable written during buffer loading aborts the load and drops buffered data.
// - Lock-set store within four cycles programs lock bits from low working register only.
// - Lock-set select clears on completion or when no store comes within four cycles.
// - Load within three cycles of lock-set arming returns lock or fuse bits by pointer bit zero.
// - Page-write store within four cycles writes buffer into page from upper pointer bits.
// - Page-write select clears on completion or four-cycle timeout.
// - Page-erase store within four cycles erases page at upper pointer bits; clears likewise.
// - CPU halted for whole programming operation when target page is in no-rww section.
// - Store alone writes working register pair into buffer at pointer word address.
// - store_enable clears after a store or four idle cycles; stays high through programming.
// - Writes whose low five bits are no defined command combination only update the interrupt enable bit.
// - Six lock bits, zero means programmed, restored only by chip erase.
// - Both memory lock bits unprogrammed: no memory lock restrictions.
// - First memory lock bit programmed: external programming blocked and fuses locked.
// - Both memory lock bits programmed: external program and verify blocked, lock and fuses locked.
// - Application lock modes 2 and 3 refuse stores to application section.
// - Application modes 3 and 4 block boot-code loads of application; interrupt gating applies.
// - Boot modes 2 and 3 refuse boot stores; modes 3 and 4 block application loads of boot.
// - Page select from pointer bits 14..7, word select from bits 6..1.
`ifndef FLASH_SP_DEFINES_SVH
`define FLASH_SP_DEFINES_SVH

// ----------------------------------------
// Control and status bit positions
// ----------------------------------------
`define BIT_IRQ_EN      7
`define BIT_RWW_BUSY    6
`define BIT_SIG_READ    5
`define BIT_REENABLE    4
`define BIT_LOCK_SET    3
`define BIT_PAGE_WRITE  2
`define BIT_PAGE_ERASE  1
`define BIT_STORE_EN    0
`define CSR_RESET       8'h00

// Accepted low-five-bit command codes
`define CMD_REENABLE    5'h11
`define CMD_LOCK_SET    5'h09
`define CMD_PAGE_WRITE  5'h05
`define CMD_PAGE_ERASE  5'h03
`define CMD_STORE_ONLY  5'h01

// ----------------------------------------
// Timing windows in CPU clock cycles
// ----------------------------------------
`define STORE_WINDOW    3'd4
`define LOAD_WINDOW     3'd3

// ----------------------------------------
// Lock bits and flash layout (word addresses)
// ----------------------------------------
`define LOCK_RESET      6'h3f
`define LOCK_MEM_LO     0
`define LOCK_MEM_HI     1
`define LOCK_APP_LO     2
`define LOCK_APP_HI     3
`define LOCK_BOOT_LO    4
`define LOCK_BOOT_HI    5
`define RWW_LIMIT       14'h3800
`define BOOT_START_256  14'h3f00
`define BOOT_START_512  14'h3e00
`define BOOT_START_1K   14'h3c00
`define BOOT_START_2K   14'h3800

`endif

// >>> flash_sp_pkg.sv
// Types shared by the flash self-programming controller.
// Assumes the constants header is compiled alongside.
package flash_sp_pkg;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_PROG = 2'b10
   } seqState_t;

endpackage : flash_sp_pkg

// >>> arm_window_timer.sv
// Down-counter that holds an arming window open for a fixed number of cycles.
// Assumes start and cancel are single-cycle strobes on core_clk.
module arm_window_timer #(
   parameter int              WIDTH  = 3,
   parameter logic [WIDTH-1:0] LENGTH = 3'd4
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic clkEn,
   // Control
   input  wire logic start,
   input  wire logic cancel,
   // Status
   output logic      active,
   output logic      expire
);

   logic [WIDTH-1:0] count_reg;

   // Reload on start; the first armed cycle is the one after the write edge
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (clkEn) begin
         if (start) begin
            count_reg <= LENGTH;
         end else if (cancel) begin
            count_reg <= '0;
         end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   // Expire marks the last armed cycle passing unused
   assign active = (count_reg != '0);
   assign expire = clkEn && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) && !start && !cancel;

endmodule : arm_window_timer

// >>> flash_array_model.sv
// Behavioural flash array: answers each erase or write strobe with a done pulse.
// Assumes strobes are one-cycle pulses on core_clk; real array time is shortened.
module flash_array_model #(
   parameter int LATENCY = 6
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Programming strobes
   input  wire logic pageErase,
   input  wire logic pageWrite,
   // Completion
   output logic      flashDone
);
   int unsigned count;

   // Countdown per operation; keeps the controller busy long enough to probe it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         count <= 0;
         flashDone <= 1'b0;
      end else begin
         count <= (pageErase || pageWrite) ? LATENCY : (count > 0 ? count - 1 : 0);
         flashDone <= (count == 1);
      end
   end
endmodule : flash_array_model

// >>> flash_self_program_control_assertions.sv
// Port-level checker for the flash self-programming controller.
// Assumes one clock domain with synchronous active-low reset.
module flash_sp_checker (
   // Clock, reset and CPU side
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        clkEn,
   input wire logic        csrWrEn,
   input wire logic [7:0]  csrWrData,
   input wire logic [7:0]  csrRdData,
   input wire logic        storeInstr,
   input wire logic [15:0] pointerZ,
   input wire logic [7:0]  lowWorkingReg,
   input wire logic [7:0]  highWorkingReg,
   input wire logic        globalIntEn,
   // Flash side and status
   input wire logic        bufWrite,
   input wire logic [5:0]  bufWordAddr,
   input wire logic [15:0] bufWriteData,
   input wire logic        pageErase,
   input wire logic        pageWrite,
   input wire logic [7:0]  pageAddr,
   input wire logic        spmReadyIrq,
   input wire logic        cpuHalt,
   input wire logic        rwwReadBlock,
   input wire logic [5:0]  lockBits,
   input wire logic        extVerifyBlocked,
   input wire logic        fuseLocked
);
   logic [15:0] zPrev;
   logic [15:0] wordPrev;

   // Pointer and word pair seen at the store, compared one cycle later
   always_ff @(posedge core_clk) begin
      zPrev <= pointerZ;
      wordPrev <= {highWorkingReg, lowWorkingReg};
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   a_irq_level: assert property (spmReadyIrq == (csrRdData[7] & globalIntEn & ~csrRdData[0]))
      else $error("store-ready interrupt level wrong");
   a_busy_block: assert property (rwwReadBlock == csrRdData[6])
      else $error("read block differs from busy flag");
   a_busy_set: assert property ((pageErase || pageWrite) && pageAddr < 8'he0 |-> rwwReadBlock)
      else $error("busy flag not set for rww page");
   a_no_rww_section_halt: assert property ((pageErase || pageWrite) && pageAddr >= 8'he0 |-> cpuHalt)
      else $error("cpu not halted for no-rww page");
   a_arm_timeout: assert property (csrWrEn && clkEn && !csrRdData[0] && csrWrData[4:0] == 5'h01
      ##1 (clkEn && !storeInstr)[*4] |=> csrRdData[4:0] == 5'h00) else $error("arming did not lapse");
   a_buffer_word: assert property (csrWrEn && clkEn && !csrRdData[0] && csrWrData[5:0] == 6'h01
      ##1 storeInstr && clkEn |=> bufWrite && bufWordAddr == zPrev[6:1] && bufWriteData == wordPrev)
      else $error("buffer word write wrong");
   a_erase_page: assert property (csrWrEn && clkEn && !csrRdData[0] && csrWrData[4:0] == 5'h03
      ##1 storeInstr && clkEn && lockBits == 6'h3f |=> pageErase && pageAddr == zPrev[14:7])
      else $error("page erase not started");
   a_lock_modes: assert property (fuseLocked == (lockBits[1:0] != 2'b11)
      && extVerifyBlocked == (lockBits[1:0] == 2'b00)) else $error("memory lock mode outputs wrong");
endmodule : flash_sp_checker

bind flash_self_program_control flash_sp_checker flash_sp_checker_inst (.*);

// >>> flash_self_program_control_test.sv
// Self-checking bench for the flash self-programming controller.
// Assumes the flash array model answers erase and write strobes.
module flash_self_program_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, csrWrEn = 1'b0, storeInstr = 1'b0;
   logic        loadInstr = 1'b0, globalIntEn = 1'b0, chipErase = 1'b0, flashDone;
   logic        bufWrite, bufDiscard, pageErase, pageWrite, loadSpecialValid, spmReadyIrq, cpuHalt;
   logic        rwwReadBlock, extVerifyBlocked, fuseLocked, extProgBlocked, bootLockLocked, loadDenied, irqBlock;
   logic [7:0]  csrWrData = 8'h00, lowWorkingReg = 8'h00, highWorkingReg = 8'h00;
   logic [7:0]  csrRdData, pageAddr, loadSpecialData;
   logic [15:0] pointerZ = 16'h0000, bufWriteData;
   logic [5:0]  bufWordAddr, lockBits;
   logic [7:0]  badCodes [4] = '{8'h02, 8'h06, 8'h13, 8'h1f};
   logic [7:0]  expLoad [3] = '{8'ha5, 8'hff, 8'h5a};
   logic [7:0]  lockCode [3] = '{8'hf3, 8'hfe, 8'hfc};
   logic [5:0]  lockExp [3] = '{6'h33, 6'h32, 6'h30};
   int          numErrors = 0;
   int          testsRun = 0;

   always #10 core_clk = ~core_clk;

   // Signature and fuse bytes are arbitrary values
   flash_self_program_control flash_self_program_control_inst (.*, .execInBoot(1'b1), .vectorsInBoot(1'b0),
      .bootSizeSel(2'b00), .fuseLowByte(8'h5a), .signatureByte(8'ha5));
   flash_array_model flash_array_model_inst (.*);

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      testsRun++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wrapUp();
      if (numErrors == 0 && testsRun > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrapUp

   // Each access starts and ends at a falling edge
   task automatic csr(input logic [7:0] d);
      csrWrEn = 1'b1;
      csrWrData = d;
      @(negedge core_clk);
      csrWrEn = 1'b0;
   endtask : csr

   task automatic spm(input logic [15:0] z, input logic [15:0] w);
      storeInstr = 1'b1;
      pointerZ = z;
      {highWorkingReg, lowWorkingReg} = w;
      @(negedge core_clk);
      storeInstr = 1'b0;
   endtask : spm

   // Bounded poll of store_enable; a hung operation ends the run
   task automatic waitIdle();
      for (int i = 0; i < 50 && csrRdData[0] !== 1'b0; i++) @(negedge core_clk);
      if (csrRdData[0] !== 1'b0) begin
         chk(csrRdData, 8'h00);
         wrapUp();
      end
   endtask : waitIdle

   initial begin
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      chk(csrRdData, 8'h00);
      chk(lockBits, 6'h3f);
      csr(8'h01);
      spm(16'h0047, 16'hbeef);
      chk({bufWrite, bufWordAddr}, {1'b1, 6'h23});
      chk(bufWriteData, 16'hbeef);
      // Arming lapses after four idle cycles, a late store is dropped
      csr(8'h01);
      repeat (3) @(negedge core_clk);
      chk(csrRdData, 8'h01);
      @(negedge core_clk);
      chk(csrRdData, 8'h00);
      spm(16'h0002, 16'h1234);
      chk(bufWrite, 1'b0);
      // Frozen clock enable does not use up the window
      csr(8'h01);
      clkEn = 1'b0;
      repeat (6) @(negedge core_clk);
      clkEn = 1'b1;
      spm(16'h0004, 16'h5678);
      chk(bufWrite, 1'b1);
      foreach (badCodes[i]) begin
         csr(badCodes[i]);
         chk(csrRdData, 8'h00);
         @(negedge core_clk);
      end
      // Rww erase; re-enable is refused until it ends, a buffer load frees the section
      csr(8'h03);
      spm(16'h0800, 16'h0000);
      chk({pageErase, pageAddr, rwwReadBlock, cpuHalt}, {1'b1, 8'h10, 2'b10});
      csr(8'h11);
      chk(csrRdData, 8'h43);
      waitIdle();
      chk(rwwReadBlock, 1'b1);
      csr(8'h01);
      spm(16'h0000, 16'h0000);
      chk(rwwReadBlock, 1'b0);
      csr(8'h05);
      spm(16'h7000, 16'h0000);
      chk({pageWrite, pageAddr, cpuHalt, rwwReadBlock}, {1'b1, 8'he0, 2'b10});
      waitIdle();
      chk(cpuHalt, 1'b0);
      csr(8'h05);
      spm(16'h0800, 16'h0000);
      waitIdle();
      csr(8'h11);
      spm(16'h0000, 16'h0000);
      chk(rwwReadBlock, 1'b0);
      // Re-enable while words are buffered throws them away
      csr(8'h01);
      spm(16'h0002, 16'h0102);
      csr(8'h11);
      chk(bufDiscard, 1'b1);
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < 3; i++) begin
         csr(i == 0 ? 8'h21 : 8'h09);
         loadInstr = 1'b1;
         pointerZ = {15'h0000, i == 2};
         @(negedge core_clk);
         loadInstr = 1'b0;
         chk({loadSpecialValid, loadSpecialData}, {1'b1, expLoad[i]});
         repeat (4) @(negedge core_clk);
      end
      foreach (lockCode[i]) begin
         csr(8'h09);
         spm(16'hffff, {8'hff, lockCode[i]});
         @(negedge core_clk);
         chk({lockBits, fuseLocked, extVerifyBlocked, extProgBlocked, bootLockLocked},
             {lockExp[i], i > 0, i > 1, i > 0, i > 1});
      end
      // Application lock mode 3 drops an erase there
      csr(8'h03);
      spm(16'h0800, 16'h0000);
      chk({pageErase, csrRdData[0]}, 2'b00);
      // Boot code may not read the locked application section
      loadInstr = 1'b1;
      @(negedge core_clk);
      loadInstr = 1'b0;
      chk({loadDenied, irqBlock}, 2'b10);
      chipErase = 1'b1;
      @(negedge core_clk);
      chipErase = 1'b0;
      chk(lockBits, 6'h3f);
      globalIntEn = 1'b1;
      csr(8'h80);
      chk(spmReadyIrq, 1'b1);
      @(negedge core_clk);
      csr(8'h81);
      chk(spmReadyIrq, 1'b0);
      wrapUp();
   end
endmodule : flash_self_program_control_test
